// ---- logic/nvac_pkg.sv ----
// Shared constants for the nonvolatile byte store access block
// How it works
// RQ1: Store holds 128 bytes; each access moves one byte at nv_location.
// RQ2: nv_location keeps seven bits, resets to zero, top bit reads zero.
// RQ3: nv_control sits at 40H of bank 1, reached through the indirect window.
// RQ4: nv_location and nv_byte_buffer sit in bank 0, directly addressed; buffer resets zero. The code decodes them in every bank, direct or not.
// RQ5: store_permit is bit 3, resets zero; while zero no write starts.
// RQ6: Bit 2 starts a write only if store_permit already set; cleared at end.
// RQ7: fetch_permit is bit 1, resets zero; while zero no read starts.
// RQ8: Bit 0 starts a read only if fetch_permit set; cleared when byte valid.
// RQ9: Firmware never sets all four bits at once, nor both starts together.
// RQ10: Firmware waits for a stable subsidiary clock before any write.
// RQ11: Firmware leaves the block's registers alone until a write completes.
// RQ12: After a read the buffer holds the byte until another operation.
// RQ13: Firmware loads location and data, sets permit, then write start next cycle.
// RQ14: Firmware masks global interrupts around starting a write.
// RQ15: Write duration comes from a timer running off the subsidiary clock.
// RQ16: Write end shows both as cleared write start and as interrupt flag.
// RQ17: Reset clears store_permit so no write occurs until firmware enables one.
// RQ18: Write end sets nv_irq_flag and the multi-function flag.
// RQ19: Vector request needs all three enables set and a stack not full.
// RQ20: Servicing the interrupt clears both the multi-function and nv flags.
// RQ21: bank_field picks banks 0 to 3; resets to 0 except watchdog idle reset.
// RQ22: Firmware never enters idle or sleep during a read or write.
// RQ23: While a cycle runs, start bits are ignored and location and data latched.
package nvac_pkg;
  localparam int unsigned AW            = 7;
  localparam int unsigned DEPTH         = 128;
  localparam logic [7:0]  OFS_BANK_SEL  = 8'h04;
  localparam logic [7:0]  OFS_LOCATION  = 8'h2A;
  localparam logic [7:0]  OFS_BYTE_BUF  = 8'h2B;
  localparam logic [7:0]  OFS_IRQ_CTRL  = 8'h2C;
  localparam logic [7:0]  OFS_CONTROL   = 8'h40;
  localparam logic [1:0]  BANK_CONTROL  = 2'h1;
  localparam logic [1:0]  BANK_DIRECT   = 2'h0;
  localparam logic [1:0]  RST_BANK      = 2'h0;
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam int unsigned BIT_STORE_PERMIT = 3;
  localparam int unsigned BIT_WR_START     = 2;
  localparam int unsigned BIT_FETCH_PERMIT = 1;
  localparam int unsigned BIT_RD_START     = 0;
  localparam int unsigned BIT_NV_IRQ_EN    = 0;
  localparam int unsigned BIT_MF_IRQ_EN    = 1;
  localparam int unsigned BIT_NV_IRQ_FLAG  = 2;
  localparam int unsigned BIT_MF_IRQ_FLAG  = 3;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned READ_TIME_NS  = 20;
  localparam int unsigned READ_CYCLES   = (READ_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WRITE_TICKS   = 64;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_FETCH = 3'b010,
    ST_STORE = 3'b100
  } nvac_state_e;
endpackage : nvac_pkg

// ---- logic/nvac_store.sv ----
// Byte array of the nonvolatile store, flip-flop based
module nvac_store #(
  parameter int unsigned AW    = nvac_pkg::AW,
  parameter int unsigned DEPTH = nvac_pkg::DEPTH
) (
  // Clock
  input  wire logic          i_mclk,
  // Access
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [7:0]    i_wdata,
  output logic      [7:0]    o_rdata
);
  // Contents are kept across reset, as the real cells would be
  logic [7:0] mem_q [DEPTH];

  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem_q[i_addr] <= i_wdata; // RQ1
    end
    o_rdata <= mem_q[i_addr];
  end
endmodule : nvac_store

// ---- logic/nvac_tick_timer.sv ----
// Write cycle timer counting edges of the subsidiary clock pin
module nvac_tick_timer #(
  parameter int unsigned TICKS = nvac_pkg::WRITE_TICKS
) (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst,
  // Subsidiary clock pin
  input  wire logic i_sub_clk,
  // Control
  input  wire logic i_start,
  output logic      o_done
);
  localparam int unsigned CW = $clog2(TICKS + 1);

  logic          sync1_q;
  logic          sync2_q;
  logic          prev_q;
  logic          run_q;
  logic [CW-1:0] cnt_q;
  wire           tick;
  wire           last;

  assign tick = sync2_q & ~prev_q;
  assign last = run_q & tick & (cnt_q == CW'(1));

  // Pin is asynchronous to i_mclk, so it is synchronised before edge detection
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      sync1_q <= i_sub_clk;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      run_q  <= 1'b0;
      cnt_q  <= '0;
      o_done <= 1'b0;
    end else begin
      o_done <= last; // RQ15
      if (i_start) begin
        run_q <= 1'b1;
        cnt_q <= CW'(TICKS);
      end else if (last) begin
        run_q <= 1'b0;
      end else if (run_q && tick) begin
        cnt_q <= cnt_q - 1'b1; // RQ15
      end
    end
  end
endmodule : nvac_tick_timer

// ---- logic/nvac_ctrl.sv ----
// Access controller for the nonvolatile byte store: registers, cycles, interrupt
module nvac_ctrl #(
  parameter int unsigned AW        = nvac_pkg::AW,
  parameter int unsigned DEPTH     = nvac_pkg::DEPTH,
  parameter int unsigned RD_CYCLES = nvac_pkg::READ_CYCLES,
  parameter int unsigned WR_TICKS  = nvac_pkg::WRITE_TICKS
) (
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic       i_wdt_idle_rst,
  // Special function register port
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic       i_sfr_direct,
  input  wire logic       i_sfr_wr,
  input  wire logic [7:0] i_sfr_wdata,
  output logic      [7:0] o_sfr_rdata,
  output logic      [1:0] o_bank,
  // Subsidiary clock pin
  input  wire logic       i_sub_clk,
  // Interrupt
  input  wire logic       i_global_irq_enable,
  input  wire logic       i_stack_full,
  input  wire logic       i_irq_ack,
  output logic            o_irq_req,
  // Status
  output logic            o_busy
);
  localparam int unsigned RCW = $clog2(RD_CYCLES + 1);

  if (AW > 7 || DEPTH != (1 << AW)) begin : g_bad_depth
    $error("nvac_ctrl: depth must be 2**AW with AW at most 7");
  end
  // The store answers one cycle after its address, so a read needs two cycles
  if (RD_CYCLES < 2) begin : g_bad_read
    $error("nvac_ctrl: RD_CYCLES must be at least 2");
  end
  if (WR_TICKS < 1) begin : g_bad_write
    $error("nvac_ctrl: WR_TICKS must be at least 1");
  end

  nvac_pkg::nvac_state_e state_q;
  nvac_pkg::nvac_state_e state_d;

  logic [1:0]     bank_q;
  logic [AW-1:0]  loc_q;
  logic [7:0]     buf_q;
  logic [AW-1:0]  lat_loc_q;
  logic [7:0]     lat_data_q;
  logic           store_permit_q;
  logic           fetch_permit_q;
  logic           wr_start_q;
  logic           rd_start_q;
  logic [RCW-1:0] rd_cnt_q;
  logic           nv_en_q;
  logic           mf_en_q;
  logic           nv_flag_q;
  logic           mf_flag_q;
  logic [7:0]     store_rdata;
  logic           tmr_done;

  wire [1:0] eff_bank;
  wire       sel_ctl;
  wire       sel_loc;
  wire       sel_buf;
  wire       sel_bank;
  wire       sel_irq;
  wire       wr_ctl;
  wire       idle;
  wire       go_wr;
  wire       go_rd;
  wire       rd_end;
  wire       wr_end;
  wire [7:0] ctl_rd;
  wire [7:0] irq_rd;
  wire [7:0] rdata_d;

  // Address decode; direct access always lands in bank 0
  assign eff_bank = i_sfr_direct ? nvac_pkg::BANK_DIRECT : bank_q;
  assign sel_ctl  = (i_sfr_addr == nvac_pkg::OFS_CONTROL)
                  && (eff_bank == nvac_pkg::BANK_CONTROL); // RQ3
  assign sel_loc  = i_sfr_addr == nvac_pkg::OFS_LOCATION; // RQ4
  assign sel_buf  = i_sfr_addr == nvac_pkg::OFS_BYTE_BUF; // RQ4
  assign sel_bank = i_sfr_addr == nvac_pkg::OFS_BANK_SEL;
  assign sel_irq  = i_sfr_addr == nvac_pkg::OFS_IRQ_CTRL;
  assign wr_ctl   = i_sfr_wr & sel_ctl;

  // Starts look at the permit already held, not the one written alongside
  assign idle  = state_q == nvac_pkg::ST_IDLE;
  assign go_wr = wr_ctl & idle & store_permit_q
               & i_sfr_wdata[nvac_pkg::BIT_WR_START]; // RQ5 RQ6 RQ23
  // Write wins if firmware breaks the one-start-at-a-time habit
  assign go_rd = wr_ctl & idle & fetch_permit_q & ~go_wr
               & i_sfr_wdata[nvac_pkg::BIT_RD_START]; // RQ7 RQ8 RQ9
  assign rd_end = (state_q == nvac_pkg::ST_FETCH) && (rd_cnt_q == '0);
  assign wr_end = (state_q == nvac_pkg::ST_STORE) && tmr_done;

  assign ctl_rd = (8'(store_permit_q) << nvac_pkg::BIT_STORE_PERMIT)
                | (8'(wr_start_q) << nvac_pkg::BIT_WR_START)
                | (8'(fetch_permit_q) << nvac_pkg::BIT_FETCH_PERMIT)
                | (8'(rd_start_q) << nvac_pkg::BIT_RD_START);
  assign irq_rd = (8'(nv_en_q) << nvac_pkg::BIT_NV_IRQ_EN)
                | (8'(mf_en_q) << nvac_pkg::BIT_MF_IRQ_EN)
                | (8'(nv_flag_q) << nvac_pkg::BIT_NV_IRQ_FLAG)
                | (8'(mf_flag_q) << nvac_pkg::BIT_MF_IRQ_FLAG);
  assign rdata_d = sel_ctl  ? ctl_rd
                 : sel_loc  ? 8'(loc_q) // RQ2
                 : sel_buf  ? buf_q
                 : sel_bank ? 8'(bank_q)
                 : sel_irq  ? irq_rd
                 : nvac_pkg::RST_BYTE;

  // Vector request only with all enables and room on the stack
  assign o_irq_req = i_global_irq_enable & nv_en_q & mf_en_q & nv_flag_q
                   & mf_flag_q & ~i_stack_full; // RQ19
  assign o_bank = bank_q;
  assign o_busy = ~idle;

  nvac_store #(
    .AW    (AW),
    .DEPTH (DEPTH)
  ) u_store (
    .i_mclk  (i_mclk),
    .i_we    (wr_end),
    .i_addr  (lat_loc_q),
    .i_wdata (lat_data_q),
    .o_rdata (store_rdata)
  );

  nvac_tick_timer #(
    .TICKS (WR_TICKS)
  ) u_timer (
    .i_mclk    (i_mclk),
    .i_rst     (i_rst),
    .i_sub_clk (i_sub_clk),
    .i_start   (go_wr),
    .o_done    (tmr_done)
  );

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      nvac_pkg::ST_IDLE: begin
        if (go_wr) begin
          state_d = nvac_pkg::ST_STORE;
        end else if (go_rd) begin
          state_d = nvac_pkg::ST_FETCH;
        end
      end
      nvac_pkg::ST_FETCH: begin
        if (rd_end) begin
          state_d = nvac_pkg::ST_IDLE;
        end
      end
      nvac_pkg::ST_STORE: begin
        if (wr_end) begin
          state_d = nvac_pkg::ST_IDLE;
        end
      end
      // Three of eight codes are used; any other falls back to idle
      default: begin
        state_d = nvac_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_q  <= nvac_pkg::ST_IDLE;
      rd_cnt_q <= '0;
    end else begin
      state_q <= state_d;
      if (go_rd) begin
        rd_cnt_q <= RCW'(RD_CYCLES - 1);
      end else if (rd_cnt_q != '0) begin
        rd_cnt_q <= rd_cnt_q - 1'b1;
      end
    end
  end

  // A watchdog wake from idle keeps the bank; every other reset clears it
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      if (!i_wdt_idle_rst) begin
        bank_q <= nvac_pkg::RST_BANK; // RQ21
      end
    end else if (i_sfr_wr && sel_bank) begin
      bank_q <= i_sfr_wdata[1:0]; // RQ21
    end
  end

  // Location and data follow firmware only between cycles
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      loc_q <= '0; // RQ2
      buf_q <= nvac_pkg::RST_BYTE; // RQ4
    end else begin
      if (i_sfr_wr && sel_loc && idle) begin
        loc_q <= i_sfr_wdata[AW-1:0]; // RQ2 RQ23
      end
      if (rd_end) begin
        buf_q <= store_rdata; // RQ8 RQ12
      end else if (i_sfr_wr && sel_buf && idle) begin
        buf_q <= i_sfr_wdata; // RQ23
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      lat_loc_q  <= '0;
      lat_data_q <= nvac_pkg::RST_BYTE;
    end else if (go_wr || go_rd) begin
      lat_loc_q  <= loc_q; // RQ1 RQ23
      lat_data_q <= buf_q;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      store_permit_q <= 1'b0; // RQ17
      fetch_permit_q <= 1'b0; // RQ7
    end else if (wr_ctl) begin
      store_permit_q <= i_sfr_wdata[nvac_pkg::BIT_STORE_PERMIT]; // RQ5
      fetch_permit_q <= i_sfr_wdata[nvac_pkg::BIT_FETCH_PERMIT]; // RQ7
    end
  end

  // Start bits are cleared only by hardware once their cycle is over
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      wr_start_q <= 1'b0;
      rd_start_q <= 1'b0;
    end else begin
      if (go_wr) begin
        wr_start_q <= 1'b1; // RQ6
      end else if (wr_end) begin
        wr_start_q <= 1'b0; // RQ6 RQ16
      end
      if (go_rd) begin
        rd_start_q <= 1'b1; // RQ8
      end else if (rd_end) begin
        rd_start_q <= 1'b0; // RQ8
      end
    end
  end

  // A write end in the same cycle as a clear keeps the flag set
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      nv_en_q   <= 1'b0;
      mf_en_q   <= 1'b0;
      nv_flag_q <= 1'b0;
      mf_flag_q <= 1'b0;
    end else begin
      if (i_sfr_wr && sel_irq) begin
        nv_en_q <= i_sfr_wdata[nvac_pkg::BIT_NV_IRQ_EN];
        mf_en_q <= i_sfr_wdata[nvac_pkg::BIT_MF_IRQ_EN];
      end
      if (wr_end) begin
        nv_flag_q <= 1'b1; // RQ16 RQ18
        mf_flag_q <= 1'b1; // RQ18
      end else if (i_irq_ack) begin
        nv_flag_q <= 1'b0; // RQ20
        mf_flag_q <= 1'b0; // RQ20
      end else if (i_sfr_wr && sel_irq) begin
        nv_flag_q <= i_sfr_wdata[nvac_pkg::BIT_NV_IRQ_FLAG];
        mf_flag_q <= i_sfr_wdata[nvac_pkg::BIT_MF_IRQ_FLAG];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_sfr_rdata <= nvac_pkg::RST_BYTE;
    end else begin
      o_sfr_rdata <= rdata_d;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  sequence s_rd_go;
    idle && go_rd;
  endsequence

  sequence s_wr_done;
    state_q == nvac_pkg::ST_STORE && tmr_done;
  endsequence

  property p_loc_top_zero;
    sel_loc |=> o_sfr_rdata[7] == 1'b0;
  endproperty
  a_loc_top_zero: assert property (p_loc_top_zero) else $error("location top bit read as one"); // RQ2

  property p_no_wr_unpermitted;
    idle && wr_ctl && !store_permit_q |=> !wr_start_q && state_q != nvac_pkg::ST_STORE;
  endproperty
  a_no_wr_unpermitted: assert property (p_no_wr_unpermitted) else $error("write began without permit"); // RQ5 RQ6

  property p_no_rd_unpermitted;
    idle && wr_ctl && !fetch_permit_q |=> !rd_start_q && state_q != nvac_pkg::ST_FETCH;
  endproperty
  a_no_rd_unpermitted: assert property (p_no_rd_unpermitted) else $error("read began without permit"); // RQ7 RQ8

  property p_rd_length;
    s_rd_go |=> rd_start_q [*4] ##1 !rd_start_q && idle;
  endproperty
  a_rd_length: assert property (p_rd_length) else $error("read cycle length wrong"); // RQ8

  property p_wr_end_report;
    s_wr_done |=> !wr_start_q && nv_flag_q && mf_flag_q && idle;
  endproperty
  a_wr_end_report: assert property (p_wr_end_report) else $error("write end not reported"); // RQ16 RQ18

  property p_buf_holds;
    idle && !rd_end && !(i_sfr_wr && sel_buf) |=> $stable(buf_q);
  endproperty
  a_buf_holds: assert property (p_buf_holds) else $error("byte buffer changed unasked"); // RQ12

  property p_latch_holds;
    !idle && !rd_end && !wr_end |=> $stable(lat_loc_q) && $stable(lat_data_q) && $stable(loc_q);
  endproperty
  a_latch_holds: assert property (p_latch_holds) else $error("latched access moved mid cycle"); // RQ23

  property p_irq_gate;
    o_irq_req |-> i_global_irq_enable && !i_stack_full && nv_en_q && mf_en_q;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("vector request without enables"); // RQ19

  property p_irq_raise;
    s_wr_done ##1 (i_global_irq_enable && nv_en_q && mf_en_q && !i_stack_full) |-> o_irq_req;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("write end raised no vector request"); // RQ18 RQ19

  property p_irq_service;
    i_irq_ack && !wr_end |=> !nv_flag_q && !mf_flag_q;
  endproperty
  a_irq_service: assert property (p_irq_service) else $error("flags survived service"); // RQ20

  property p_permit_reset;
    disable iff (1'b0) i_rst |=> !store_permit_q && !wr_start_q;
  endproperty
  a_permit_reset: assert property (p_permit_reset) else $error("permit survived reset"); // RQ17

  property p_bank_reset;
    disable iff (1'b0) i_rst && !i_wdt_idle_rst |=> bank_q == nvac_pkg::RST_BANK;
  endproperty
  a_bank_reset: assert property (p_bank_reset) else $error("bank not cleared by reset"); // RQ21
endmodule : nvac_ctrl

// ---- test/nvac_fw_model.sv ----
// Firmware core model: register port driver, global enable and subsidiary clock
module nvac_fw_model (
  // Clock
  input  wire logic       i_mclk,
  // Register port
  input  wire logic [7:0] i_sfr_rdata,
  output logic      [7:0] o_sfr_addr,
  output logic            o_sfr_direct,
  output logic            o_sfr_wr,
  output logic      [7:0] o_sfr_wdata,
  // Core side signals
  output logic            o_gie,
  output logic            o_sub_clk,
  // Captured read result
  output logic            o_rd_stb,
  output logic      [7:0] o_rd_val
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_sfr_addr   = 8'h00;
    o_sfr_direct = 1'b1;
    o_sfr_wr     = 1'b0;
    o_sfr_wdata  = 8'h00;
    o_gie        = 1'b1;
    o_sub_clk    = 1'b0;
    o_rd_stb     = 1'b0;
    o_rd_val     = 8'h00;
  end

  // Runs from time zero, so it is settled long before the first write
  always #50 o_sub_clk = ~o_sub_clk;

  task automatic put(input logic [7:0] a, input logic d, input logic [7:0] v);
    @(negedge i_mclk);
    o_sfr_addr   = a;
    o_sfr_direct = d;
    o_sfr_wdata  = v;
    o_sfr_wr     = 1'b1;
  endtask : put

  task automatic sfr_wr(input logic [7:0] a, input logic d, input logic [7:0] v);
    put(a, d, v);
    @(negedge i_mclk);
    o_sfr_wr = 1'b0;
  endtask : sfr_wr

  // Read data shows one cycle after the address, so capture it then
  task automatic sfr_rd(input logic [7:0] a, input logic d);
    @(negedge i_mclk);
    o_sfr_addr   = a;
    o_sfr_direct = d;
    @(negedge i_mclk);
    o_rd_val = i_sfr_rdata;
    o_rd_stb = 1'b1;
    @(negedge i_mclk);
    o_rd_stb = 1'b0;
  endtask : sfr_rd

  // Control is reached only indirectly, with the bank already at one
  task automatic store(input logic [6:0] loc, input logic [7:0] v);
    sfr_wr(nvac_pkg::OFS_LOCATION, 1'b1, {1'b0, loc});
    sfr_wr(nvac_pkg::OFS_BYTE_BUF, 1'b1, v);
    o_gie = 1'b0;
    put(nvac_pkg::OFS_CONTROL, 1'b0, 8'h08);
    put(nvac_pkg::OFS_CONTROL, 1'b0, 8'h0C);
    @(negedge i_mclk);
    o_sfr_wr = 1'b0;
    o_gie    = 1'b1;
  endtask : store

  task automatic fetch(input logic [6:0] loc);
    sfr_wr(nvac_pkg::OFS_LOCATION, 1'b1, {1'b0, loc});
    put(nvac_pkg::OFS_CONTROL, 1'b0, 8'h02);
    put(nvac_pkg::OFS_CONTROL, 1'b0, 8'h03);
    @(negedge i_mclk);
    o_sfr_wr = 1'b0;
  endtask : fetch
endmodule : nvac_fw_model

// ---- test/test_nvac_ctrl.sv ----
// Self-checking testbench of the store access controller
module test_nvac_ctrl;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] LOC  = nvac_pkg::OFS_LOCATION;
  localparam logic [7:0] BUF  = nvac_pkg::OFS_BYTE_BUF;
  localparam logic [7:0] CTL  = nvac_pkg::OFS_CONTROL;
  localparam logic [7:0] IRQ  = nvac_pkg::OFS_IRQ_CTRL;
  localparam logic [7:0] BSEL = nvac_pkg::OFS_BANK_SEL;

  logic       i_mclk     = 1'b0;
  logic       i_rst      = 1'b1;
  logic       wdt_idle   = 1'b0;
  logic       stack_full = 1'b0;
  logic       irq_ack    = 1'b0;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic [7:0] rdata;
  logic [7:0] rd_val;
  logic       sfr_direct;
  logic       sfr_wr;
  logic       gie;
  logic       sub_clk;
  logic       rd_stb;
  logic [1:0] bank;
  logic       irq_req;
  logic       busy;
  logic [7:0] exp_q[$];
  logic [6:0] locs[4];
  logic [7:0] vals[4];
  logic [31:0] rnd;
  int         errors     = 0;
  int         num_checks = 0;
  int         seed       = 47416;

  always #2.5 i_mclk = ~i_mclk;

  nvac_ctrl #(.WR_TICKS(2)) nvac_ctrl_inst (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_wdt_idle_rst(wdt_idle),
    .i_sfr_addr(sfr_addr), .i_sfr_direct(sfr_direct), .i_sfr_wr(sfr_wr),
    .i_sfr_wdata(sfr_wdata), .o_sfr_rdata(rdata), .o_bank(bank),
    .i_sub_clk(sub_clk), .i_global_irq_enable(gie), .i_stack_full(stack_full),
    .i_irq_ack(irq_ack), .o_irq_req(irq_req), .o_busy(busy));

  nvac_fw_model nvac_fw_model_inst (
    .i_mclk(i_mclk), .i_sfr_rdata(rdata), .o_sfr_addr(sfr_addr),
    .o_sfr_direct(sfr_direct), .o_sfr_wr(sfr_wr), .o_sfr_wdata(sfr_wdata),
    .o_gie(gie), .o_sub_clk(sub_clk), .o_rd_stb(rd_stb), .o_rd_val(rd_val));

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : cmp

  task automatic chk_flag(input logic got, input logic exp);
    cmp({7'h00, got}, {7'h00, exp});
  endtask : chk_flag

  // Results come back in request order, so the oldest note matches
  always @(posedge i_mclk) begin
    if (rd_stb === 1'b1) begin
      if (exp_q.size() == 0) begin
        cmp(rd_val, 8'hXX);
      end else begin
        cmp(rd_val, exp_q.pop_front());
      end
    end
  end

  task automatic rd(input logic [7:0] a, input logic d, input logic [7:0] e);
    exp_q.push_back(e);
    nvac_fw_model_inst.sfr_rd(a, d);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic d, input logic [7:0] v);
    nvac_fw_model_inst.sfr_wr(a, d, v);
  endtask : wr

  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(negedge i_mclk);
      n++;
    end
    chk_flag(busy, 1'b0);
  endtask : wait_idle

  task automatic pulse_rst(input logic keep);
    wdt_idle = keep;
    i_rst    = 1'b1;
    repeat (2) @(negedge i_mclk);
    i_rst    = 1'b0;
    wdt_idle = 1'b0;
  endtask : pulse_rst

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  initial begin
    #100000;
    errors++;
    $display("Watchdog expired at %0t", $time);
    stop_test();
  end

  initial begin
    repeat (20) @(negedge i_mclk);
    i_rst = 1'b0;
    rd(LOC, 1'b1, 8'h00);
    rd(BUF, 1'b1, 8'h00);
    rd(BSEL, 1'b1, 8'h00);
    wr(LOC, 1'b1, 8'hFF);
    rd(LOC, 1'b1, 8'h7F);
    wr(BSEL, 1'b1, 8'h01);
    rd(CTL, 1'b0, 8'h00);
    wr(CTL, 1'b0, 8'h05);
    chk_flag(busy, 1'b0);
    rd(CTL, 1'b0, 8'h00);
    wr(CTL, 1'b0, 8'h0C);
    chk_flag(busy, 1'b0);
    rd(CTL, 1'b0, 8'h08);
    rd(CTL, 1'b1, 8'h00);
    $display("Refused starts test done");
    wr(IRQ, 1'b1, 8'h03);
    for (int k = 0; k < 4; k++) begin
      rnd = $random(seed);
      locs[k] = {rnd[6:2], k[1:0]};
      vals[k] = rnd[15:8];
      nvac_fw_model_inst.store(locs[k], vals[k]);
      chk_flag(busy, 1'b1);
      wait_idle();
      rd(CTL, 1'b0, 8'h08);
      rd(IRQ, 1'b1, 8'h0F);
      chk_flag(irq_req, 1'b1);
      stack_full = 1'b1;
      @(negedge i_mclk);
      chk_flag(irq_req, 1'b0);
      stack_full = 1'b0;
      irq_ack    = 1'b1;
      @(negedge i_mclk);
      irq_ack = 1'b0;
      rd(IRQ, 1'b1, 8'h03);
      chk_flag(irq_req, 1'b0);
      nvac_fw_model_inst.fetch(locs[k]);
      chk_flag(busy, 1'b1);
      wr(LOC, 1'b1, {1'b0, ~locs[k]});
      wait_idle();
      rd(CTL, 1'b0, 8'h02);
      rd(BUF, 1'b1, vals[k]);
      rd(LOC, 1'b1, {1'b0, locs[k]});
      rd(BUF, 1'b1, vals[k]);
    end
    for (int k = 0; k < 4; k++) begin
      nvac_fw_model_inst.fetch(locs[k]);
      wait_idle();
      rd(BUF, 1'b1, vals[k]);
    end
    $display("Store and fetch test done");
    wr(BSEL, 1'b1, 8'h03);
    cmp({6'h00, bank}, 8'h03);
    chk_flag(busy, 1'b0);
    pulse_rst(1'b1);
    rd(BSEL, 1'b1, 8'h03);
    rd(BUF, 1'b1, 8'h00);
    pulse_rst(1'b0);
    rd(BSEL, 1'b1, 8'h00);
    wr(BSEL, 1'b1, 8'h01);
    rd(CTL, 1'b0, 8'h00);
    wr(CTL, 1'b0, 8'h04);
    chk_flag(busy, 1'b0);
    wr(IRQ, 1'b1, 8'h0F);
    rd(IRQ, 1'b1, 8'h0F);
    chk_flag(irq_req, 1'b1);
    irq_ack = 1'b1;
    @(negedge i_mclk);
    irq_ack = 1'b0;
    chk_flag(irq_req, 1'b0);
    $display("Reset and bank test done");
    stop_test();
  end
endmodule : test_nvac_ctrl
